// ==== fan_drive_ramp.sv ====
// package of shared constants, plus the soft-switch ramp for one coil output
// assumes one 50 MHz clock and a one-cycle microsecond enable from the top
`timescale 1ns/10ps
`default_nettype none

package fan_pkg;
	localparam int CLK_FREQ_MHZ      = 50;
	localparam int TON_TYP_MS        = 500;
	localparam int TON_MIN_MS        = 350;
	localparam int TON_MAX_MS        = 650;
	localparam int LOCK_OFF_ON_RATIO = 10;
	localparam int SLOPE_TIME_US     = 100;
	localparam int US_PER_MS         = 1000;
	localparam int CLK_PER_US        = CLK_FREQ_MHZ;
	localparam int TON_TYP_US        = TON_TYP_MS * US_PER_MS;
endpackage

module fan_drive_ramp
	import fan_pkg::*;
#(
	parameter int SLOPE_US = SLOPE_TIME_US
) (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_srst,
	// timing
	input  wire logic i_us_tick,
	input  wire logic i_pwm_wrap,
	// control
	input  wire logic i_target,
	// output
	output logic      o_drive
);
	localparam int LW = $clog2(SLOPE_US + 1);
	localparam logic [LW-1:0] LEVEL_FULL = LW'(SLOPE_US);
	localparam logic [LW-1:0] LEVEL_ZERO = '0;
	localparam logic [LW-1:0] LEVEL_STEP = LW'(1);

	generate
		if (SLOPE_US < 1) begin : g_bad
			$error("slope must be at least one microsecond");
		end
	endgenerate

	// ----------------------------------------------------------------
	// level ramp and pwm
	// ----------------------------------------------------------------
	logic [LW-1:0] level_q;
	logic [LW-1:0] level_d;
	logic [LW-1:0] phase_q;
	logic [LW-1:0] phase_d;
	logic          drive_d;
	wire           go_up;
	wire           go_dn;

	// one step per microsecond: full swing takes the slope time
	assign go_up   = i_us_tick && i_target && (level_q != LEVEL_FULL);
	assign go_dn   = i_us_tick && !i_target && (level_q != LEVEL_ZERO);
	assign level_d = go_up ? level_q + LEVEL_STEP :
	                 go_dn ? level_q - LEVEL_STEP : level_q;
	assign phase_d = (i_pwm_wrap || phase_q == LEVEL_FULL - LEVEL_STEP) ?
	                 LEVEL_ZERO : phase_q + LEVEL_STEP;
	// duty equals level over slope; full level is a steady high
	assign drive_d = (level_q == LEVEL_FULL) || (phase_q < level_q);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			level_q <= LEVEL_ZERO;
			phase_q <= LEVEL_ZERO;
			o_drive <= 1'b0;
		end else begin
			level_q <= level_d;
			phase_q <= phase_d;
			o_drive <= drive_d;
		end
	end
endmodule

`default_nettype wire

// ==== fan_lock_commutator.sv ====
// single-coil fan commutation, rotor lock retry and tach output
// assumes a raw hall polarity pin and an external pull-up on the tach line

`timescale 1ns/10ps
`default_nettype none

module fan_lock_commutator
	import fan_pkg::*;
#(
	parameter int ON_TIME_US = TON_TYP_US,
	parameter int OFF_RATIO  = LOCK_OFF_ON_RATIO,
	parameter int SLOPE_US   = SLOPE_TIME_US,
	parameter int TICK_CLKS  = CLK_PER_US
) (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_srst,
	// hall sensor, high for north
	input  wire logic i_hall_north,
	// coil bridge
	output logic      o_coil_drive_a,
	output logic      o_coil_drive_b,
	// open-drain tach
	output logic      o_rotation_pulse_out,
	output logic      o_rotation_pulse_out_oe,
	// status
	output logic      o_locked
);
	localparam int OFF_TIME_US = ON_TIME_US * OFF_RATIO;
	localparam int TW = $clog2(OFF_TIME_US + 1);
	localparam int PW = $clog2(TICK_CLKS + 1);
	localparam logic [TW-1:0] T_ON   = TW'(ON_TIME_US);
	localparam logic [TW-1:0] T_OFF  = TW'(OFF_TIME_US);
	localparam logic [TW-1:0] T_ONE  = TW'(1);
	localparam logic [TW-1:0] T_ZERO = '0;
	localparam logic [PW-1:0] P_LAST = PW'(TICK_CLKS - 1);
	localparam logic [PW-1:0] P_ONE  = PW'(1);
	localparam logic [PW-1:0] P_ZERO = '0;

	generate
		// a zero on time would never expire and never declare a lock
		if (ON_TIME_US < 1 || OFF_RATIO < 1 ||
		    TICK_CLKS < 1 || SLOPE_US < 1) begin : g_bad
			$error("fan timing parameters out of range");
		end
	endgenerate

	typedef enum logic [1:0] {
		SPIN,
		LOCK_OFF,
		LOCK_ON
	} mode_t;

	// ----------------------------------------------------------------
	// hall synchroniser and microsecond enable
	// ----------------------------------------------------------------
	logic          hall_meta_q;
	logic          hall_q;
	logic          hall_prev_q;
	logic [PW-1:0] pre_q;
	wire           us_tick;
	wire           hall_edge;

	assign us_tick   = (pre_q == P_LAST);
	assign hall_edge = (hall_q != hall_prev_q);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			hall_meta_q <= 1'b0;
			hall_q      <= 1'b0;
			hall_prev_q <= 1'b0;
			pre_q       <= P_ZERO;
		end else begin
			hall_meta_q <= i_hall_north;
			hall_q      <= hall_meta_q;
			hall_prev_q <= hall_q;
			pre_q       <= us_tick ? P_ZERO : pre_q + P_ONE;
		end
	end

	// ----------------------------------------------------------------
	// lock state machine
	// ----------------------------------------------------------------
	mode_t         mode_q;
	mode_t         mode_d;
	logic [TW-1:0] timer_q;
	logic [TW-1:0] timer_d;
	logic          lock_pole_q;
	wire           timer_done;

	assign timer_done = us_tick && (timer_q == T_ONE);

	always_comb begin
		mode_d  = mode_q;
		timer_d = (us_tick && timer_q != T_ZERO) ? timer_q - T_ONE : timer_q;
		unique case (mode_q)
			SPIN: begin
				// stall watch: one full on time without a polarity change
				if (hall_edge) begin
					timer_d = T_ON;
				end else if (timer_done) begin
					mode_d  = LOCK_OFF;
					timer_d = T_OFF;
				end
			end
			LOCK_OFF: begin
				if (hall_edge) begin
					mode_d  = SPIN;
					timer_d = T_ON;
				end else if (timer_done) begin
					mode_d  = LOCK_ON;
					timer_d = T_ON;
				end
			end
			LOCK_ON: begin
				if (hall_edge) begin
					mode_d  = SPIN;
					timer_d = T_ON;
				end else if (timer_done) begin
					mode_d  = LOCK_OFF;
					timer_d = T_OFF;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			mode_q      <= SPIN;
			timer_q     <= T_ON;
			lock_pole_q <= 1'b0;
		end else begin
			mode_q  <= mode_d;
			timer_q <= timer_d;
			if (mode_q == SPIN && mode_d == LOCK_OFF) begin
				lock_pole_q <= hall_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// coil targets and tach
	// ----------------------------------------------------------------
	logic tgt_a_q;
	logic tgt_b_q;
	logic fg_q;
	wire  tgt_a_d;
	wire  tgt_b_d;
	wire  lock_on;

	assign lock_on = (mode_q == LOCK_ON);
	// south drives a, north drives b; locked pole pulses only its own side
	assign tgt_a_d = (mode_q == SPIN) ? !hall_q :
	                 (lock_on && !lock_pole_q);
	assign tgt_b_d = (mode_q == SPIN) ? hall_q :
	                 (lock_on && lock_pole_q);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			tgt_a_q              <= 1'b0;
			tgt_b_q              <= 1'b0;
			fg_q                 <= 1'b0;
			o_locked             <= 1'b0;
			o_rotation_pulse_out <= 1'b0;
		end else begin
			tgt_a_q              <= tgt_a_d;
			tgt_b_q              <= tgt_b_d;
			o_locked             <= (mode_d != SPIN);
			o_rotation_pulse_out <= 1'b0;
			// lock pulses are not rotation, so the tach holds there
			if (mode_q == SPIN && tgt_a_d && !tgt_a_q) begin
				fg_q <= !fg_q;
			end
		end
	end

	// open drain: enable pulls the line low, pull-up gives the high
	assign o_rotation_pulse_out_oe = fg_q;

	// ----------------------------------------------------------------
	// soft-switched outputs
	// ----------------------------------------------------------------
	fan_drive_ramp #(
		.SLOPE_US (SLOPE_US)
	) u_ramp_a (
		.i_clk      (i_clk),
		.i_srst     (i_srst),
		.i_us_tick  (us_tick),
		.i_pwm_wrap (1'b0),
		.i_target   (tgt_a_q),
		.o_drive    (o_coil_drive_a)
	);

	fan_drive_ramp #(
		.SLOPE_US (SLOPE_US)
	) u_ramp_b (
		.i_clk      (i_clk),
		.i_srst     (i_srst),
		.i_us_tick  (us_tick),
		.i_pwm_wrap (1'b0),
		.i_target   (tgt_b_q),
		.o_drive    (o_coil_drive_b)
	);
endmodule

`default_nettype wire

// ==== fan_monitor.sv ====
// checker on the commutator top ports
// assumes one clock and the short lock timing
`timescale 1ns/10ps
`default_nettype none
module fan_monitor #(
	parameter int ON_TIME_US = 20,
	parameter int OFF_RATIO  = 10,
	parameter int SLOPE_US   = 4,
	parameter int TICK_CLKS  = 2
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_hall_north,
	input wire logic o_coil_drive_a,
	input wire logic o_coil_drive_b,
	input wire logic o_rotation_pulse_out,
	input wire logic o_rotation_pulse_out_oe,
	input wire logic o_locked
);
	// ----------
	// properties
	// ----------
	// margins absorb the 1 us tick quantisation
	localparam int ONC = ON_TIME_US * TICK_CLKS;
	localparam int OFC = ONC * OFF_RATIO;
	localparam int SLC = (SLOPE_US + 2) * TICK_CLKS + 4;
	int stall_q;
	int lock_q;
	always_ff @(posedge i_clk) begin
		stall_q <= (i_srst || $changed(i_hall_north)) ? 0 : stall_q + 1;
		lock_q <= o_locked ? lock_q + 1 : 0;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	sequence s_held; ($stable(i_hall_north) && o_locked) [*8]; endsequence
	sequence s_late; stall_q == ONC + 4 * TICK_CLKS + 8; endsequence
	property p_zero; !o_rotation_pulse_out; endproperty
	property p_src;
		$changed(o_rotation_pulse_out_oe) |-> !$past(i_hall_north, 3);
	endproperty
	property p_late; s_late |-> o_locked; endproperty
	property p_resume; $changed(i_hall_north) |-> ##[1:6] !o_locked; endproperty
	property p_side;
		s_held |-> (i_hall_north ? !o_coil_drive_a : !o_coil_drive_b);
	endproperty
	property p_off; lock_q > SLC && lock_q < OFC - 8 |->
		!o_coil_drive_a && !o_coil_drive_b; endproperty
	property p_on; lock_q > OFC + SLC && lock_q < OFC + ONC - 8 |->
		o_coil_drive_a ^ o_coil_drive_b; endproperty
	property p_retry; lock_q == 2 * OFC + ONC + SLC |->
		o_coil_drive_a ^ o_coil_drive_b; endproperty
	a_zero: assert property (p_zero) else $error("fg data high");
	a_src: assert property (p_src) else $error("fg toggle");
	a_late: assert property (p_late) else $error("no lock");
	a_resume: assert property (p_resume) else $error("no resume");
	a_side: assert property (p_side) else $error("lock side");
	a_off: assert property (p_off) else $error("lock off");
	a_on: assert property (p_on) else $error("lock on");
	a_retry: assert property (p_retry) else $error("no retry");
endmodule
bind fan_lock_commutator fan_monitor #(.ON_TIME_US(ON_TIME_US),
	.OFF_RATIO(OFF_RATIO), .SLOPE_US(SLOPE_US), .TICK_CLKS(TICK_CLKS))
	fan_monitor_inst (
	.i_clk                   (i_clk),
	.i_srst                  (i_srst),
	.i_hall_north            (i_hall_north),
	.o_coil_drive_a          (o_coil_drive_a),
	.o_coil_drive_b          (o_coil_drive_b),
	.o_rotation_pulse_out    (o_rotation_pulse_out),
	.o_rotation_pulse_out_oe (o_rotation_pulse_out_oe),
	.o_locked                (o_locked)
);
`default_nettype wire

// ==== fan_world.sv ====
// rotor magnet and pulled-up tach line
// assumes run and pole change just after a clock edge
`timescale 1ns/10ps
`default_nettype none
module fan_world #(
	parameter int HALF = 24
) (
	input  wire logic i_clk,
	input  wire logic i_run,
	input  wire logic i_pole,
	input  wire logic i_tach_oe,
	output logic      o_hall_north,
	output logic      o_tach_line
);
	// -----
	// rotor
	// -----
	int   n = 0;
	logic run_s;
	logic pole_s;
	initial o_hall_north = 1'b0;
	// released line floats up through the pull-up
	assign o_tach_line = i_tach_oe ? 1'b0 : 1'b1;
	always @(posedge i_clk) begin
		// take the bench levels at the edge, never while they move
		run_s  = i_run;
		pole_s = i_pole;
		#2;
		n = run_s ? n + 1 : 0;
		if (!run_s)
			o_hall_north = pole_s;
		else if (n % HALF == 0)
			o_hall_north = !o_hall_north;
	end
endmodule
`default_nettype wire

// ==== fan_lock_commutator_test.sv ====
// self-checking bench for the fan commutator
// assumes fan_world for hall and tach, short timing
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
	end end
module fan_lock_commutator_test;
	// -----------
	// bench state
	// -----------
	localparam int ONC = 40;
	localparam int OFC = ONC * 10;
	logic i_clk  = 1'b0;
	logic i_srst = 1'b1;
	logic run    = 1'b0;
	logic pole   = 1'b0;
	logic hall, a, b, fg, fg_oe, locked, line;
	int err_total = 0;
	int samples_checked = 0;
	int tog = 0;
	int cyc = 0;
	always #10 i_clk = ~i_clk;
	always @(fg_oe) tog++;
	fan_lock_commutator #(.ON_TIME_US(20), .OFF_RATIO(10), .SLOPE_US(4),
		.TICK_CLKS(2)) fan_lock_commutator_inst (.i_clk, .i_srst,
		.i_hall_north(hall), .o_coil_drive_a(a), .o_coil_drive_b(b),
		.o_rotation_pulse_out(fg), .o_rotation_pulse_out_oe(fg_oe),
		.o_locked(locked));
	fan_world fan_world_inst (.i_clk, .i_run(run), .i_pole(pole),
		.i_tach_oe(fg_oe), .o_hall_north(hall), .o_tach_line(line));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard, far above the roughly 2500 cycles needed
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			finish_test();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#2;
	endtask
	task automatic spin_test();
		int t0;
		int hi;
		logic l0;
		hi = 0;
		run = 1'b1;
		tick(100);
		@(negedge hall);
		t0 = tog;
		l0 = line;
		repeat (11) begin
			@(posedge i_clk);
			#1 hi += (a === 1'b1);
		end
		`CHK(hi < 8, 1'b1)
		tick(9);
		`CHK({a, b, fg, locked}, 4'h8)
		`CHK(line, !l0)
		tick(24);
		`CHK({a, b, fg, locked}, 4'h4)
		tick(436);
		`CHK(tog - t0, 10)
		`CHK(line, l0)
		$display("spin test done");
	endtask
	task automatic lock_test(input logic p);
		int t;
		int off_hi;
		int on_hi;
		int on2;
		int oth;
		{t, off_hi, on_hi, on2, oth} = '0;
		pole = p;
		run = 1'b0;
		while (locked !== 1'b1 && t < ONC + 20) begin
			tick(1);
			t++;
		end
		`CHK(locked, 1'b1)
		tick(16);
		for (int i = 0; i < 2 * OFC + ONC + 8; i++) begin
			tick(1);
			if ((p ? b : a) === 1'b1) begin
				if (i < OFC - 24) off_hi++;
				else if (i < OFC + OFC / 2) on_hi++;
				else on2++;
			end
			oth += ((p ? a : b) === 1'b1);
		end
		`CHK(off_hi, 0)
		`CHK(on_hi > ONC - 10 && on_hi < ONC + 10, 1'b1)
		`CHK(on2 > 0 && locked === 1'b1, 1'b1)
		`CHK(oth, 0)
		pole = !p;
		t = 0;
		while (locked !== 1'b0 && t < 12) begin
			tick(1);
			t++;
		end
		`CHK(locked, 1'b0)
		run = 1'b1;
		$display("lock test done");
	endtask
	initial begin
		tick(12);
		i_srst = 1'b0;
		spin_test();
		lock_test(1'b0);
		lock_test(1'b1);
		finish_test();
	end
endmodule
`default_nettype wire
